/* File: logic/ettcu_timer_top.sv */
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/10ps
module ettcu_timer_top (
   input  wire logic       I_SYS_CLK,
   input  wire logic       I_RST_N,
   input  wire logic [2:0] I_ADDR,
   input  wire logic [7:0] I_WDATA,
   input  wire logic       I_WR,
   input  wire logic       I_RD,
   output logic      [7:0] O_RDATA,
   input  wire logic       I_TIMER_POWER_REDUCE,
   input  wire logic       I_CRYSTAL_PIN_IN,
   output logic            O_CRYSTAL_PIN_OUT,
   input  wire logic       I_EXT_PIN,
   input  wire logic       I_ACK_OVF,
   input  wire logic       I_ACK_CMP_A,
   input  wire logic       I_ACK_CMP_B,
   output logic            O_IRQ_OVF,
   output logic            O_IRQ_CMP_A,
   output logic            O_IRQ_CMP_B,
   output logic            O_COMPARE_OUTPUT_A,
   output logic            O_COMPARE_OUTPUT_A_EN,
   output logic            O_COMPARE_OUTPUT_B,
   output logic            O_COMPARE_OUTPUT_B_EN,
   output logic            O_COUNT_BOTTOM,
   output logic            O_COUNT_MAX,
   output logic            O_MATCH_A,
   output logic            O_MATCH_B
);
   typedef struct packed {
      logic [1:0] wgm_lo;
      logic [1:0] com_a;
      logic [1:0] com_b;
      logic [2:0] cs;
      logic       wgm2;
      logic       async_sel;
      logic [7:0] count;
      logic [7:0] cmp_a;
      logic [7:0] cmp_b;
      logic [7:0] buf_a;
      logic [7:0] buf_b;
      logic       count_up;
      logic       block;
      logic [2:0] flags;
      logic [2:0] mask;
      logic       oc_a;
      logic       oc_b;
      logic [7:0] rdata;
   } ettcu_st_t;

   ettcu_st_t  st_ff;
   ettcu_st_t  nxt_st;
   logic       tick;
   logic [2:0] mode;
   logic [7:0] top;
   logic       pwm_fast;
   logic       pwm_phase;
   logic       pwm;
   logic       match_a;
   logic       match_b;
   logic       hit_a;
   logic       hit_b;
   logic       at_top;
   logic       ovf_set;
   logic       reload;
   logic [2:0] set_f;
   logic [2:0] clr_f;
   logic       wr_ca;
   logic       wr_cb;
   logic       wr_cnt;

   // Applies a non-PWM compare action to the current output state.
   function automatic logic ettcu_act(input logic oc, input logic [1:0] com);
      logic r;
      r = oc;
      case (com)
         ettcu_pkg::COM_TOGGLE: r = ~oc;
         ettcu_pkg::COM_CLEAR:  r = 1'b0;
         ettcu_pkg::COM_SET:    r = 1'b1;
         default:               r = oc;
      endcase
      return r;
   endfunction

   // Tick source: prescaler, crystal and external pin selection.
   // The prescaler runs free and is not cleared on a select change, so the first
   // prescaled tick after a start may come early; software must allow for that.
   ettcu_tick_gen #(
      .PRE_W (10)
   ) u_tick (
      .i_clk             (I_SYS_CLK),
      .i_rst_n           (I_RST_N),
      .i_cs              (st_ff.cs),
      .i_async_sel       (st_ff.async_sel),
      .i_hold            (I_TIMER_POWER_REDUCE),
      .i_crystal_pin_in  (I_CRYSTAL_PIN_IN),
      .i_ext_pin         (I_EXT_PIN),
      .o_tick            (tick),
      .o_crystal_pin_out (O_CRYSTAL_PIN_OUT)
   );

   // Mode decode and the always-on comparators.
   always_comb begin
      mode      = {st_ff.wgm2, st_ff.wgm_lo};
      pwm_fast  = (mode == ettcu_pkg::MODE_FAST_MAX) || (mode == ettcu_pkg::MODE_FAST_A);
      pwm_phase = (mode == ettcu_pkg::MODE_PC_MAX) || (mode == ettcu_pkg::MODE_PC_A);
      pwm       = pwm_fast | pwm_phase;
      // Only CTC and the two compare-A-topped PWM modes move TOP off MAX.
      if ((mode == ettcu_pkg::MODE_CTC) || (mode == ettcu_pkg::MODE_PC_A)
          || (mode == ettcu_pkg::MODE_FAST_A)) begin
         top = st_ff.cmp_a;
      end else begin
         top = ettcu_pkg::CNT_MAX;
      end
      at_top  = (st_ff.count == top);
      match_a = (st_ff.count == st_ff.cmp_a);
      match_b = (st_ff.count == st_ff.cmp_b);
      // A recent count write suppresses matches until the next tick has passed.
      hit_a   = tick & match_a & ~st_ff.block;
      hit_b   = tick & match_b & ~st_ff.block;
   end

   // Next state: counting, buffering, waveforms, flags and the register port.
   always_comb begin
      nxt_st   = st_ff;
      ovf_set  = 1'b0;
      reload   = 1'b0;
      wr_ca    = I_WR && (I_ADDR == ettcu_pkg::OFF_CTRL_A);
      wr_cb    = I_WR && (I_ADDR == ettcu_pkg::OFF_CTRL_B);
      wr_cnt   = I_WR && (I_ADDR == ettcu_pkg::OFF_COUNT);

      // Counter sequence on each tick.
      if (tick) begin
         nxt_st.block = 1'b0;
         if (pwm_fast) begin
            if (at_top) begin
               nxt_st.count = ettcu_pkg::CNT_BOTTOM;
               ovf_set      = 1'b1;
               reload       = 1'b1;
            end else begin
               nxt_st.count = st_ff.count + ettcu_pkg::CNT_ONE;
            end
         end else if (pwm_phase) begin
            if (st_ff.count_up) begin
               if (at_top) begin
                  nxt_st.count_up = 1'b0;
                  nxt_st.count    = st_ff.count - ettcu_pkg::CNT_ONE;
                  reload          = 1'b1;
               end else begin
                  nxt_st.count = st_ff.count + ettcu_pkg::CNT_ONE;
               end
            end else if (st_ff.count == ettcu_pkg::CNT_BOTTOM) begin
               nxt_st.count_up = 1'b1;
               nxt_st.count    = ettcu_pkg::CNT_ONE;
            end else begin
               nxt_st.count = st_ff.count - ettcu_pkg::CNT_ONE;
               if (st_ff.count == ettcu_pkg::CNT_ONE) begin
                  ovf_set         = 1'b1;
                  nxt_st.count_up = 1'b1;
               end
            end
         end else if ((mode == ettcu_pkg::MODE_CTC) && at_top) begin
            nxt_st.count = ettcu_pkg::CNT_BOTTOM;
            ovf_set      = (st_ff.count == ettcu_pkg::CNT_MAX);
         end else begin
            // Normal mode and reserved codes: plain upward wrap.
            nxt_st.count = st_ff.count + ettcu_pkg::CNT_ONE;
            ovf_set      = (st_ff.count == ettcu_pkg::CNT_MAX);
         end
         if (!pwm) begin
            nxt_st.count_up = 1'b1;
         end
      end

      // Buffered compare values move into the comparators at TOP or BOTTOM.
      if (reload) begin
         nxt_st.cmp_a = st_ff.buf_a;
         nxt_st.cmp_b = st_ff.buf_b;
      end

      // Waveform generation on a real match.
      if (pwm_fast) begin
         if (hit_a) begin
            nxt_st.oc_a = (st_ff.com_a == ettcu_pkg::COM_SET);
            if (st_ff.com_a == ettcu_pkg::COM_TOGGLE) begin
               nxt_st.oc_a = st_ff.wgm2 ? ~st_ff.oc_a : st_ff.oc_a;
            end
         end
         if (hit_b && (st_ff.com_b[1] == 1'b1)) begin
            nxt_st.oc_b = st_ff.com_b[0];
         end
         // At the wrap to BOTTOM the output returns to its active level.
         if (tick && at_top) begin
            if (st_ff.com_a[1]) begin
               nxt_st.oc_a = ~st_ff.com_a[0];
            end
            if (st_ff.com_b[1]) begin
               nxt_st.oc_b = ~st_ff.com_b[0];
            end
         end
      end else if (pwm_phase) begin
         // Matches clear while rising and set while falling; inverted for the set code.
         if (hit_a && st_ff.com_a[1]) begin
            nxt_st.oc_a = st_ff.com_a[0] ^ ~st_ff.count_up;
         end else if (hit_a && (st_ff.com_a == ettcu_pkg::COM_TOGGLE) && st_ff.wgm2) begin
            nxt_st.oc_a = ~st_ff.oc_a;
         end
         if (hit_b && st_ff.com_b[1]) begin
            nxt_st.oc_b = st_ff.com_b[0] ^ ~st_ff.count_up;
         end
      end else begin
         if (hit_a) begin
            nxt_st.oc_a = ettcu_act(st_ff.oc_a, st_ff.com_a);
         end
         if (hit_b) begin
            nxt_st.oc_b = ettcu_act(st_ff.oc_b, st_ff.com_b);
         end
      end

      // Register writes.
      if (wr_ca) begin
         nxt_st.wgm_lo = I_WDATA[ettcu_pkg::CA_WGM_LO +: 2];
         nxt_st.com_b  = I_WDATA[ettcu_pkg::CA_COM_B_LO +: 2];
         nxt_st.com_a  = I_WDATA[ettcu_pkg::CA_COM_A_LO +: 2];
      end
      if (wr_cb) begin
         nxt_st.cs   = I_WDATA[ettcu_pkg::CB_CS_LO +: 3];
         nxt_st.wgm2 = I_WDATA[ettcu_pkg::CB_WGM2];
         // Force strobes act only in non-PWM modes and touch neither flags nor count.
         if (!pwm && I_WDATA[ettcu_pkg::CB_FOC_A]) begin
            nxt_st.oc_a = ettcu_act(st_ff.oc_a, st_ff.com_a);
         end
         if (!pwm && I_WDATA[ettcu_pkg::CB_FOC_B]) begin
            nxt_st.oc_b = ettcu_act(st_ff.oc_b, st_ff.com_b);
         end
      end
      // The CPU write is applied last so that it overrides the tick's count and block updates.
      // Blocking only the next tick lets software preload a compare value equal
      // to the count without raising a spurious flag when the clock starts.
      if (wr_cnt) begin
         nxt_st.count = I_WDATA;
         nxt_st.block = 1'b1;
      end
      // Reads return the buffer, which equals the live value outside PWM modes.
      if (I_WR && (I_ADDR == ettcu_pkg::OFF_CMP_A)) begin
         nxt_st.buf_a = I_WDATA;
         if (!pwm) begin
            nxt_st.cmp_a = I_WDATA;
         end
      end
      if (I_WR && (I_ADDR == ettcu_pkg::OFF_CMP_B)) begin
         nxt_st.buf_b = I_WDATA;
         if (!pwm) begin
            nxt_st.cmp_b = I_WDATA;
         end
      end
      if (I_WR && (I_ADDR == ettcu_pkg::OFF_MASK)) begin
         nxt_st.mask = I_WDATA[2:0];
      end
      if (I_WR && (I_ADDR == ettcu_pkg::OFF_ASYNC)) begin
         nxt_st.async_sel = I_WDATA[ettcu_pkg::AS_SEL];
      end

      // Flags: a set in the same cycle as a clear wins, so no event is lost.
      // Service pulses come from logic on this clock, so they need no synchroniser.
      set_f                       = '0;
      set_f[ettcu_pkg::FL_OVF]    = ovf_set;
      set_f[ettcu_pkg::FL_CMP_A]  = hit_a;
      set_f[ettcu_pkg::FL_CMP_B]  = hit_b;
      clr_f                       = {I_ACK_CMP_B, I_ACK_CMP_A, I_ACK_OVF};
      if (I_WR && (I_ADDR == ettcu_pkg::OFF_FLAGS)) begin
         clr_f = clr_f | I_WDATA[2:0];
      end
      nxt_st.flags = (st_ff.flags & ~clr_f) | set_f;

      // Read data stands for one cycle only; unmapped bits read as zero.
      nxt_st.rdata = ettcu_pkg::RST_BYTE;
      if (I_RD) begin
         case (I_ADDR)
            ettcu_pkg::OFF_CTRL_A: nxt_st.rdata = {st_ff.com_a, st_ff.com_b, 2'h0, st_ff.wgm_lo};
            ettcu_pkg::OFF_CTRL_B: nxt_st.rdata = {4'h0, st_ff.wgm2, st_ff.cs};
            ettcu_pkg::OFF_COUNT:  nxt_st.rdata = st_ff.count;
            ettcu_pkg::OFF_CMP_A:  nxt_st.rdata = st_ff.buf_a;
            ettcu_pkg::OFF_CMP_B:  nxt_st.rdata = st_ff.buf_b;
            ettcu_pkg::OFF_FLAGS:  nxt_st.rdata = {5'h00, st_ff.flags};
            ettcu_pkg::OFF_MASK:   nxt_st.rdata = {5'h00, st_ff.mask};
            ettcu_pkg::OFF_ASYNC:  nxt_st.rdata = {2'h0, st_ff.async_sel, 5'h00};
            default:               nxt_st.rdata = ettcu_pkg::RST_BYTE;
         endcase
      end
   end

   // All state lives in one register; reset leaves the timer stopped in normal mode.
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_N) begin
         st_ff          <= '0;
         st_ff.count_up <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Requests are the flags gated by their individual enables.
   assign O_IRQ_OVF   = st_ff.flags[ettcu_pkg::FL_OVF] & st_ff.mask[ettcu_pkg::FL_OVF];
   assign O_IRQ_CMP_A = st_ff.flags[ettcu_pkg::FL_CMP_A] & st_ff.mask[ettcu_pkg::FL_CMP_A];
   assign O_IRQ_CMP_B = st_ff.flags[ettcu_pkg::FL_CMP_B] & st_ff.mask[ettcu_pkg::FL_CMP_B];

   // The pin is handed to the waveform only while an action is selected.
   assign O_COMPARE_OUTPUT_A    = st_ff.oc_a;
   assign O_COMPARE_OUTPUT_A_EN = (st_ff.com_a != ettcu_pkg::COM_OFF);
   assign O_COMPARE_OUTPUT_B    = st_ff.oc_b;
   assign O_COMPARE_OUTPUT_B_EN = (st_ff.com_b != ettcu_pkg::COM_OFF);
   assign O_RDATA               = st_ff.rdata;

   // Landmark and match status for the waveform stage and for observers.
   assign O_COUNT_BOTTOM = (st_ff.count == ettcu_pkg::CNT_BOTTOM);
   assign O_COUNT_MAX    = (st_ff.count == ettcu_pkg::CNT_MAX);
   assign O_MATCH_A      = match_a;
   assign O_MATCH_B      = match_b;
endmodule

/* File: logic/ettcu_pkg.sv */
// Shared offsets, field positions, reset values and mode codes for the 8-bit timer.
package ettcu_pkg;
   // Register offsets on the plain register port.
   localparam int          ADDR_W         = 3;
   localparam logic [2:0]  OFF_CTRL_A     = 3'h0;
   localparam logic [2:0]  OFF_CTRL_B     = 3'h1;
   localparam logic [2:0]  OFF_COUNT      = 3'h2;
   localparam logic [2:0]  OFF_CMP_A      = 3'h3;
   localparam logic [2:0]  OFF_CMP_B      = 3'h4;
   localparam logic [2:0]  OFF_FLAGS      = 3'h5;
   localparam logic [2:0]  OFF_MASK       = 3'h6;
   localparam logic [2:0]  OFF_ASYNC      = 3'h7;
   // Field positions in control A.
   localparam int          CA_WGM_LO      = 0;
   localparam int          CA_COM_B_LO    = 4;
   localparam int          CA_COM_A_LO    = 6;
   // Field positions in control B.
   localparam int          CB_CS_LO       = 0;
   localparam int          CB_WGM2        = 3;
   localparam int          CB_FOC_B       = 6;
   localparam int          CB_FOC_A       = 7;
   // Bit positions in the flag and mask registers.
   localparam int          FL_OVF         = 0;
   localparam int          FL_CMP_A       = 1;
   localparam int          FL_CMP_B       = 2;
   // Bit position of the clock source bit in the async status register.
   localparam int          AS_SEL         = 5;
   // Values after reset and counter landmarks.
   localparam logic [7:0]  RST_BYTE       = 8'h00;
   localparam logic [7:0]  CNT_BOTTOM     = 8'h00;
   localparam logic [7:0]  CNT_MAX        = 8'hFF;
   localparam logic [7:0]  CNT_ONE        = 8'h01;
   // Waveform mode codes.
   localparam logic [2:0]  MODE_NORMAL    = 3'h0;
   localparam logic [2:0]  MODE_PC_MAX    = 3'h1;
   localparam logic [2:0]  MODE_CTC       = 3'h2;
   localparam logic [2:0]  MODE_FAST_MAX  = 3'h3;
   localparam logic [2:0]  MODE_PC_A      = 3'h5;
   localparam logic [2:0]  MODE_FAST_A    = 3'h7;
   // Clock source codes.
   localparam logic [2:0]  CS_STOP        = 3'h0;
   localparam logic [2:0]  CS_DIV1        = 3'h1;
   localparam logic [2:0]  CS_DIV8        = 3'h2;
   localparam logic [2:0]  CS_DIV64       = 3'h3;
   localparam logic [2:0]  CS_DIV256      = 3'h4;
   localparam logic [2:0]  CS_DIV1024     = 3'h5;
   localparam logic [2:0]  CS_EXT_FALL    = 3'h6;
   localparam logic [2:0]  CS_EXT_RISE    = 3'h7;
   // Prescaler bits that must all be one for each division.
   localparam int          PRE_BITS_8     = 3;
   localparam int          PRE_BITS_64    = 6;
   localparam int          PRE_BITS_256   = 8;
   localparam int          PRE_BITS_1024  = 10;
   // Compare output action codes.
   localparam logic [1:0]  COM_OFF        = 2'h0;
   localparam logic [1:0]  COM_TOGGLE     = 2'h1;
   localparam logic [1:0]  COM_CLEAR      = 2'h2;
   localparam logic [1:0]  COM_SET        = 2'h3;
endpackage

/* File: logic/ettcu_tick_gen.sv */
// Clock selection and prescaler that turns the chosen source into timer tick pulses.
`timescale 1ns/10ps
module ettcu_tick_gen #(
   parameter int PRE_W = 10
) (
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   input  wire logic [2:0] i_cs,
   input  wire logic       i_async_sel,
   input  wire logic       i_hold,
   input  wire logic       i_crystal_pin_in,
   input  wire logic       i_ext_pin,
   output logic            o_tick,
   output logic            o_crystal_pin_out
);
   // The divide-by-1024 tap needs ten prescaler bits.
   if (PRE_W < ettcu_pkg::PRE_BITS_1024) begin : g_chk
      $error("ettcu_tick_gen: PRE_W must be at least 10");
   end

   typedef struct packed {
      logic [2:0]       xtal;
      logic [2:0]       ext;
      logic [PRE_W-1:0] pre;
      logic             xout;
   } ettcu_tick_st_t;

   ettcu_tick_st_t st_ff;
   ettcu_tick_st_t nxt_st;
   logic           base;
   logic           x_rise;
   logic           e_rise;
   logic           e_fall;

   // Stage 0 of each chain feeds only stage 1; edges are found between stages 1 and 2.
   always_comb begin
      nxt_st      = st_ff;
      nxt_st.xtal = {st_ff.xtal[1:0], i_crystal_pin_in};
      nxt_st.ext  = {st_ff.ext[1:0], i_ext_pin};
      x_rise      = st_ff.xtal[1] & ~st_ff.xtal[2];
      e_rise      = st_ff.ext[1] & ~st_ff.ext[2];
      e_fall      = ~st_ff.ext[1] & st_ff.ext[2];
      base        = i_async_sel ? x_rise : 1'b1;
      // The oscillator feedback pin drives the inverse of the settled crystal level.
      nxt_st.xout = ~st_ff.xtal[1];
      if (base) begin
         nxt_st.pre = st_ff.pre + 1'b1;
      end
      // A stopped source or a powered-down timer produces no ticks at all.
      o_tick = 1'b0;
      case (i_cs)
         ettcu_pkg::CS_STOP:     o_tick = 1'b0;
         ettcu_pkg::CS_DIV1:     o_tick = base;
         ettcu_pkg::CS_DIV8:     o_tick = base & (&st_ff.pre[ettcu_pkg::PRE_BITS_8-1:0]);
         ettcu_pkg::CS_DIV64:    o_tick = base & (&st_ff.pre[ettcu_pkg::PRE_BITS_64-1:0]);
         ettcu_pkg::CS_DIV256:   o_tick = base & (&st_ff.pre[ettcu_pkg::PRE_BITS_256-1:0]);
         ettcu_pkg::CS_DIV1024:  o_tick = base & (&st_ff.pre[ettcu_pkg::PRE_BITS_1024-1:0]);
         ettcu_pkg::CS_EXT_FALL: o_tick = e_fall;
         ettcu_pkg::CS_EXT_RISE: o_tick = e_rise;
         default:                o_tick = 1'b0;
      endcase
      if (i_hold) begin
         o_tick = 1'b0;
      end
   end

   // Single register stage for all state of the tick generator.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign o_crystal_pin_out = st_ff.xout;
endmodule

/* File: tb/ettcu_timer_chk.sv */
// Assertion checker bound to the 8-bit timer top level.
`timescale 1ns/10ps
module ettcu_timer_chk (
   input wire logic       I_SYS_CLK,
   input wire logic       I_RST_N,
   input wire logic       I_WR,
   input wire logic       I_RD,
   input wire logic [7:0] O_RDATA,
   input wire logic       I_TIMER_POWER_REDUCE,
   input wire logic       I_ACK_OVF,
   input wire logic       I_ACK_CMP_A,
   input wire logic       O_IRQ_OVF,
   input wire logic       O_IRQ_CMP_A,
   input wire logic       O_IRQ_CMP_B,
   input wire logic       O_COUNT_BOTTOM,
   input wire logic       O_COUNT_MAX,
   input wire logic       O_MATCH_A,
   input wire logic       O_MATCH_B
);
   // One clock domain, so clock and reset are given once for all properties.
   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (!I_RST_N);
   // Reset release, register port and counter landmark behaviour.
   AST_RST_STATE: assert property (
      $rose(I_RST_N) |-> O_COUNT_BOTTOM && !O_IRQ_OVF && !O_IRQ_CMP_A)
      else $error("State after reset is not cleared");
   AST_RDATA_IDLE: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
      else $error("Read data present without a read");
   AST_LANDMARK_EXCL: assert property (O_COUNT_BOTTOM |-> !O_COUNT_MAX)
      else $error("Bottom and max signalled together");
   // A compare request that rises on its own must come from a match seen one cycle earlier; an overflow request rises with the count at bottom.
   AST_CMP_A_SET: assert property (
      $rose(O_IRQ_CMP_A) && !$past(I_WR) |-> $past(O_MATCH_A))
      else $error("Compare A flag set without a prior match");
   AST_CMP_B_SET: assert property (
      $rose(O_IRQ_CMP_B) && !$past(I_WR) |-> $past(O_MATCH_B))
      else $error("Compare B flag set without a prior match");
   AST_OVF_SET: assert property (
      $rose(O_IRQ_OVF) && !$past(I_WR) |-> O_COUNT_BOTTOM)
      else $error("Overflow flag set away from bottom");
   // Service pulses clear the flag unless a new event lands in the same cycle.
   AST_ACK_OVF: assert property (I_ACK_OVF |=> !O_IRQ_OVF || O_COUNT_BOTTOM)
      else $error("Overflow request survived its service pulse");
   AST_ACK_A: assert property (I_ACK_CMP_A && !O_MATCH_A |=> !O_IRQ_CMP_A)
      else $error("Compare A request survived its service pulse");
   AST_GATED: assert property (
      I_TIMER_POWER_REDUCE && $past(I_TIMER_POWER_REDUCE) && !$past(I_WR)
      |-> $stable(O_COUNT_BOTTOM) && $stable(O_MATCH_A))
      else $error("Counter moved while ticks were gated");
   // Main scenarios reached by the bench.
   cover property ($rose(O_IRQ_CMP_A));
   cover property ($rose(O_IRQ_OVF));
   cover property (O_COUNT_MAX);
endmodule
bind ettcu_timer_top ettcu_timer_chk ettcu_timer_chk_i (
   .I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
   .I_TIMER_POWER_REDUCE(I_TIMER_POWER_REDUCE), .I_ACK_OVF(I_ACK_OVF),
   .I_ACK_CMP_A(I_ACK_CMP_A), .O_IRQ_OVF(O_IRQ_OVF), .O_IRQ_CMP_A(O_IRQ_CMP_A),
   .O_IRQ_CMP_B(O_IRQ_CMP_B), .O_COUNT_BOTTOM(O_COUNT_BOTTOM), .O_COUNT_MAX(O_COUNT_MAX),
   .O_MATCH_A(O_MATCH_A), .O_MATCH_B(O_MATCH_B));

/* File: tb/tb_top.sv */
// Self-checking bench for the 8-bit timer top level.
`timescale 1ns/10ps
module tb_top;
   logic       clk, rst_n, wr, rd, pwr, xtal, ext, ack_o, ack_a, ack_b, run;
   logic       irq_o, irq_a, irq_b, oc_a, oc_a_en, oc_b, oc_b_en, xo, bot, cmax, m_a, m_b;
   logic [1:0] cyc;
   logic [2:0] addr;
   logic [7:0] wdata, rdata, v, k;
   logic [7:0] mdl [$];
   int         n_mismatch, n_tests, i, o;
   logic [2:0] ra [5] = '{ettcu_pkg::OFF_CMP_A, ettcu_pkg::OFF_CMP_B, ettcu_pkg::OFF_MASK,
                          ettcu_pkg::OFF_CTRL_A, ettcu_pkg::OFF_CTRL_B};
   logic [7:0] wm [5] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h38};
   logic [7:0] rm [5] = '{8'hFF, 8'hFF, 8'h07, 8'hF3, 8'h08};
   logic [1:0] act [4] = '{ettcu_pkg::COM_TOGGLE, ettcu_pkg::COM_CLEAR, ettcu_pkg::COM_SET,
                           ettcu_pkg::COM_TOGGLE};
   ettcu_timer_top ettcu_timer_top_i (
      .I_SYS_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
      .I_RD(rd), .O_RDATA(rdata), .I_TIMER_POWER_REDUCE(pwr), .I_CRYSTAL_PIN_IN(xtal),
      .O_CRYSTAL_PIN_OUT(xo), .I_EXT_PIN(ext), .I_ACK_OVF(ack_o), .I_ACK_CMP_A(ack_a),
      .I_ACK_CMP_B(ack_b), .O_IRQ_OVF(irq_o), .O_IRQ_CMP_A(irq_a), .O_IRQ_CMP_B(irq_b),
      .O_COMPARE_OUTPUT_A(oc_a), .O_COMPARE_OUTPUT_A_EN(oc_a_en), .O_COMPARE_OUTPUT_B(oc_b),
      .O_COMPARE_OUTPUT_B_EN(oc_b_en), .O_COUNT_BOTTOM(bot), .O_COUNT_MAX(cmax), .O_MATCH_A(m_a),
      .O_MATCH_B(m_b));
   // 125 MHz system clock.
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Crystal and external pins move slowly so the synchronisers never miss an edge.
   always @(posedge clk) begin
      cyc <= cyc + 2'h1;
      if (run && cyc == 2'h0) begin
         xtal <= ~xtal;
         ext <= 1'($urandom_range(0, 1));
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         n_mismatch++;
      end
   endtask
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe, so sample mid-cycle there.
   task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask
   task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd_reg(a, d);
      chk(d, e);
   endtask
   task automatic ack(input logic [2:0] w);
      @(posedge clk);
      {ack_b, ack_a, ack_o} <= w;
      @(posedge clk);
      {ack_b, ack_a, ack_o} <= 3'h0;
   endtask
   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // The whole sequence needs about 16000 cycles; two and a half times that means a hang.
   initial begin
      #(8 * 40000);
      n_mismatch++;
      $display("Error at %0t: watchdog expired", $time);
      wrap_up();
   end
   // Main sequence.
   initial begin
      {rst_n, wr, rd, pwr, xtal, ext, ack_b, ack_a, ack_o, run} = 10'h000;
      {cyc, addr, wdata} = 13'h0000;
      void'($urandom(32'h6ADC9AA0));
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      for (i = 0; i < 8; i++) rd_chk(3'(i), 8'h00);
      for (i = 0; i < 5; i++) begin
         mdl.push_back(8'($urandom) & wm[i]);
         wr_reg(ra[i], mdl[i]);
         rd_chk(ra[i], mdl[i] & rm[i]);
      end
      for (i = 2; i < 5; i++) wr_reg(ra[i], 8'h00);
      $display("Register test done");
      v = 8'($urandom);
      pwr <= 1'b1;
      wr_reg(ettcu_pkg::OFF_COUNT, v);
      wr_reg(ettcu_pkg::OFF_CTRL_B, 8'h01);
      repeat (50) @(posedge clk);
      rd_chk(ettcu_pkg::OFF_COUNT, v);
      wr_reg(ettcu_pkg::OFF_CTRL_B, 8'h00);
      pwr <= 1'b0;
      repeat (50) @(posedge clk);
      rd_chk(ettcu_pkg::OFF_COUNT, v);
      $display("Stop test done");
      wr_reg(ettcu_pkg::OFF_CMP_A, 8'h07);
      wr_reg(ettcu_pkg::OFF_MASK, 8'h02);
      wr_reg(ettcu_pkg::OFF_COUNT, 8'h07);
      repeat (2) @(negedge clk);
      chk({7'h00, m_a}, 8'h01);
      wr_reg(ettcu_pkg::OFF_CTRL_B, 8'h01);
      repeat (5) @(negedge clk);
      chk({7'h00, irq_a}, 8'h00);
      for (i = 0; i < 300 && irq_a !== 1'b1; i++) @(negedge clk);
      chk({7'h00, irq_a}, 8'h01);
      wr_reg(ettcu_pkg::OFF_CTRL_B, 8'h00);
      rd_chk(ettcu_pkg::OFF_FLAGS, 8'h07);
      chk({6'h00, irq_o, irq_b}, 8'h00);
      wr_reg(ettcu_pkg::OFF_MASK, 8'h07);
      repeat (2) @(negedge clk);
      chk({6'h00, irq_o, irq_b}, 8'h03);
      ack(3'h2);
      rd_chk(ettcu_pkg::OFF_FLAGS, 8'h05);
      wr_reg(ettcu_pkg::OFF_FLAGS, 8'h01);
      rd_chk(ettcu_pkg::OFF_FLAGS, 8'h04);
      ack(3'h5);
      rd_chk(ettcu_pkg::OFF_FLAGS, 8'h00);
      $display("Compare lap test done");
      k = 8'($urandom_range(20, 60));
      wr_reg(ettcu_pkg::OFF_COUNT, 8'h00);
      wr_reg(ettcu_pkg::OFF_CMP_A, k);
      wr_reg(ettcu_pkg::OFF_CTRL_A, {6'h00, ettcu_pkg::MODE_CTC[1:0]});
      wr_reg(ettcu_pkg::OFF_CTRL_B, 8'h01);
      o = 0;
      repeat (300) begin
         @(negedge clk);
         if (cmax === 1'b1) o = 1;
      end
      wr_reg(ettcu_pkg::OFF_CTRL_B, 8'h00);
      chk(8'(o), 8'h00);
      rd_reg(ettcu_pkg::OFF_COUNT, v);
      chk({7'h00, v <= k}, 8'h01);
      rd_chk(ettcu_pkg::OFF_FLAGS, {5'h00, mdl[1] <= k, 2'h2});
      wr_reg(ettcu_pkg::OFF_CTRL_A, 8'h00);
      wr_reg(ettcu_pkg::OFF_CTRL_B, 8'h01);
      wr_reg(ettcu_pkg::OFF_COUNT, 8'h40);
      rd_reg(ettcu_pkg::OFF_COUNT, v);
      chk({7'h00, v >= 8'h40 && v <= 8'h44}, 8'h01);
      $display("Clear and priority test done");
      run <= 1'b1;
      for (i = 1; i < 8; i++) begin
         wr_reg(ettcu_pkg::OFF_CTRL_B, 8'h00);
         wr_reg(ettcu_pkg::OFF_COUNT, 8'h00);
         wr_reg(ettcu_pkg::OFF_FLAGS, 8'h07);
         wr_reg(ettcu_pkg::OFF_CTRL_B, 8'(i));
         repeat (2100) @(posedge clk);
         wr_reg(ettcu_pkg::OFF_CTRL_B, 8'h00);
         rd_reg(ettcu_pkg::OFF_COUNT, v);
         rd_reg(ettcu_pkg::OFF_FLAGS, k);
         chk({7'h00, v != 8'h00 || k[0]}, 8'h01);
      end
      $display("Clock select test done");
      run <= 1'b0;
      wr_reg(ettcu_pkg::OFF_ASYNC, 8'h20);
      wr_reg(ettcu_pkg::OFF_COUNT, 8'h00);
      wr_reg(ettcu_pkg::OFF_CTRL_B, 8'h01);
      repeat (100) @(posedge clk);
      rd_chk(ettcu_pkg::OFF_COUNT, 8'h00);
      chk({7'h00, xo}, {7'h00, ~xtal});
      run <= 1'b1;
      repeat (200) @(posedge clk);
      wr_reg(ettcu_pkg::OFF_CTRL_B, 8'h00);
      wr_reg(ettcu_pkg::OFF_ASYNC, 8'h00);
      rd_reg(ettcu_pkg::OFF_COUNT, v);
      chk({7'h00, v != 8'h00}, 8'h01);
      $display("Crystal source test done");
      wr_reg(ettcu_pkg::OFF_FLAGS, 8'h07);
      o = 0;
      for (i = 0; i < 4; i++) begin
         wr_reg(ettcu_pkg::OFF_CTRL_A, {act[i], act[i], 4'h0});
         wr_reg(ettcu_pkg::OFF_CTRL_B, 8'hC0);
         repeat (2) @(negedge clk);
         o = (act[i] == ettcu_pkg::COM_TOGGLE) ? 1 - o : int'(act[i] == ettcu_pkg::COM_SET);
         chk({4'h0, oc_b_en, oc_b, oc_a_en, oc_a}, {4'h0, 1'b1, 1'(o), 1'b1, 1'(o)});
      end
      rd_chk(ettcu_pkg::OFF_FLAGS, 8'h00);
      $display("Force compare test done");
      wrap_up();
   end
endmodule
